// ---- verif/p3s_scheduler_monitor.sv ----
// Concurrent checks on the ports of the ratio scheduler
`timescale 1ns/1ps
`default_nettype none
module p3s_scheduler_monitor
    import p3s_pkg::*;
#(
    parameter int PERIOD_CYCLES = P3S_PERIOD_CYCLES
) (
    input wire logic ref_clk_in, // Clock
    input wire logic resetn_in, // Reset, active low
    input wire logic [P3S_ADDR_W-1:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Lanes
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic [1:0] avs_response, // Response
    input wire logic [P3S_NQ-1:0] q_req_in, // Requests
    input wire logic q_ready_in, // Ready
    input wire logic [P3S_NQ-1:0] q_grant_out // Grants
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    logic acc;
    logic rd_rsvd;
    assign acc = avs_read | avs_write;
    assign rd_rsvd = avs_read && !avs_waitrequest && avs_address[9:2] >= P3S_RSVD_FIRST_IDX
        && avs_address[9:2] <= P3S_RSVD_LAST_IDX;
    a_grant_one_hot: assert property ($onehot0(q_grant_out))
        else $error("grant not one-hot");
    a_grant_gap: assert property (|q_grant_out |=> q_grant_out == '0)
        else $error("grant in two adjacent cycles");
    a_grant_cause: assert property (|q_grant_out |-> $past(q_ready_in)
        && |($past(q_req_in) & q_grant_out)) else $error("grant without request");
    a_ready_gate: assert property (!q_ready_in |=> q_grant_out == '0)
        else $error("grant while not ready");
    a_wait_first: assert property (acc && !$past(acc) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_wait_once: assert property (acc && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait longer than one cycle");
    a_idle_wait: assert property (!acc |-> !avs_waitrequest)
        else $error("stall while idle");
    a_rsvd_error: assert property (rd_rsvd |-> avs_response == 2'b10)
        else $error("reserved read not refused");
    a_rsvd_zero: assert property (rd_rsvd |-> avs_readdata == '0)
        else $error("reserved read not zero");
    c_top_grant: cover property (q_grant_out[3]);
    c_low_grant: cover property (q_grant_out[0]);
    c_rsvd_read: cover property (rd_rsvd);
endmodule
bind p3s_scheduler p3s_scheduler_monitor #(.PERIOD_CYCLES(PERIOD_CYCLES)) mon_u (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .q_req_in(q_req_in), .q_ready_in(q_ready_in), .q_grant_out(q_grant_out));
`default_nettype wire

// ---- verif/p3s_scheduler_tb_top.sv ----
// Self-checking bench for the ratio scheduler
`timescale 1ns/1ps
`default_nettype none
module p3s_scheduler_tb_top;
    import p3s_pkg::*;
    localparam int PER = 50;
    logic clk, rstn, rd, wr, rdy, ws;
    logic [9:0] adr;
    logic [31:0] wdat, rdat, d;
    logic [1:0] resp, r;
    logic [3:0] req, gnt, g;
    int num_errors, checks, cnt[4];
    p3s_scheduler #(.PERIOD_CYCLES(PER)) dut_u (.ref_clk_in(clk), .resetn_in(rstn),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(ws),
        .avs_response(resp), .q_req_in(req), .q_ready_in(rdy), .q_grant_out(gnt));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v);
        int n;
        adr <= a;
        wdat <= v;
        rd <= !w;
        wr <= w;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ws === 1'b0) break;
        end
        d = rdat;
        r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n == 20) begin
            num_errors++;
            test_done();
        end
    endtask
    task automatic count(input int cyc);
        repeat (cyc) begin
            @(posedge clk);
            for (int q = 0; q < 4; q++) if (gnt[q] === 1'b1) cnt[q]++;
        end
    endtask
    task automatic grant(input logic [3:0] v);
        int n;
        rdy <= 1'b0;
        req <= v;
        repeat (2) @(posedge clk);
        rdy <= 1'b1;
        for (n = 0; n < 10; n++) begin
            @(posedge clk);
            if (gnt !== 4'h0) break;
        end
        g = gnt;
        if (n == 10) begin
            num_errors++;
            test_done();
        end
    endtask
    initial begin
        {rd, wr, adr, wdat} = '0;
        rstn = 1'b0;
        req = 4'hf;
        rdy = 1'b1;
        num_errors = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        // All queues start in ratio mode with defaults 8, 4, 2, 1
        count(40);
        check("q3_count", cnt[3], 8);
        check("q2_count", cnt[2], 4);
        check("q1_count", cnt[1], 2);
        check("q0_count", cnt[0], 1);
        count(30);
        check("q3_reload", cnt[3], 16);
        req <= 4'h0;
        bus(1'b0, 10'h340, 0);
        check("high_rst", d, 32'h8488);
        bus(1'b0, 10'h348, 0);
        check("low_rst", d, 32'h8182);
        bus(1'b1, 10'h350, 32'hffff);
        check("rsvd_wr_resp", r, 2'b10);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 10'h350 + 10'(4 * i), 0);
            check("rsvd_data", d, 0);
            check("rsvd_resp", r, 2'b10);
        end
        bus(1'b1, 10'h340, 32'h0000);
        check("high_wr_resp", r, 2'b00);
        bus(1'b1, 10'h348, 32'h0000);
        bus(1'b0, 10'h340, 0);
        check("high_wr", d, 0);
        bus(1'b0, 10'h348, 0);
        check("low_wr", d, 0);
        // Limit zero leaves every allowance spent; no queue requests
        bus(1'b0, 10'h380, 0);
        check("status", d, 32'h000000f0);
        check("status_resp", r, 2'b00);
        grant(4'hf);
        check("strict_q3", g, 4'h8);
        grant(4'h7);
        check("strict_q2", g, 4'h4);
        grant(4'h3);
        check("strict_q1", g, 4'h2);
        grant(4'h1);
        check("strict_q0", g, 4'h1);
        cnt[0] = 0;
        count(40);
        check("q0_unlimited", cnt[0], 20);
        test_done();
    end
endmodule
`default_nettype wire

// ---- verilog/p3s_period_timer.sv ----
// Period tick divider for the ratio scheduler
`timescale 1ns/1ps
`default_nettype none
module p3s_period_timer
    import p3s_pkg::*;
#(
    parameter int PERIOD_CYCLES = P3S_PERIOD_CYCLES
) (
    input wire logic ref_clk_in, // Core clock
    input wire logic resetn_in, // Sync reset, active low
    output logic tick_out // One-cycle pulse at period start
);
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } p3s_timer_type;
    p3s_timer_type state_reg;
    p3s_timer_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.count >= 32'(PERIOD_CYCLES - 1)) begin
            state_next.count = 32'h0;
            state_next.tick = 1'b1;
        end else begin
            state_next.count = state_reg.count + 32'h1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_out = state_reg.tick;
endmodule
`default_nettype wire

// ---- verilog/p3s_pkg.sv ----
// Package for the port 3 transmit queue ratio scheduler
package p3s_pkg;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    // Printed offsets are not multiples of four: they are indices
    localparam logic [7:0] P3S_HIGH_WEIGHT_IDX = 8'hd0;
    localparam logic [7:0] P3S_LOW_WEIGHT_IDX = 8'hd2;
    localparam logic [7:0] P3S_RSVD_FIRST_IDX = 8'hd4;
    localparam logic [7:0] P3S_RSVD_LAST_IDX = 8'hdb;
    localparam logic [7:0] P3S_STATUS_IDX = 8'he0;
    localparam int P3S_ADDR_W = 10;
    // -------------------------------------------------------------------
    // Field layout
    // -------------------------------------------------------------------
    localparam int P3S_UPPER_CTRL_BIT = 15;
    localparam int P3S_UPPER_CNT_LSB = 8;
    localparam int P3S_LOWER_CTRL_BIT = 7;
    localparam int P3S_LOWER_CNT_LSB = 0;
    localparam int P3S_CNT_W = 7;
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [15:0] P3S_HIGH_WEIGHT_RST = 16'h8488;
    localparam logic [15:0] P3S_LOW_WEIGHT_RST = 16'h8182;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int P3S_PERIOD_US = 100;
    localparam int P3S_CLK_MHZ = 100;
    localparam int P3S_PERIOD_CYCLES = P3S_PERIOD_US * P3S_CLK_MHZ;
    localparam int P3S_NQ = 4;
endpackage

// ---- verilog/p3s_queue_credit.sv ----
// Per-queue packet allowance counter
`timescale 1ns/1ps
`default_nettype none
module p3s_queue_credit
    import p3s_pkg::*;
#(
    parameter int CNT_W = P3S_CNT_W
) (
    input wire logic ref_clk_in, // Core clock
    input wire logic resetn_in, // Sync reset, active low
    input wire logic reload_in, // Period start
    input wire logic [CNT_W-1:0] limit_in, // Packets allowed per period
    input wire logic used_in, // A packet was granted
    output logic spent_out // Allowance used up
);
    typedef struct packed {
        logic [CNT_W-1:0] sent;
    } p3s_credit_type;
    p3s_credit_type state_reg;
    p3s_credit_type state_next;

    always_comb begin
        state_next = state_reg;
        // Reload wins but counts a packet granted in the same cycle
        if (reload_in) begin
            state_next.sent = used_in ? CNT_W'(1) : '0;
        end else if (used_in && state_reg.sent != '1) begin
            state_next.sent = state_reg.sent + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign spent_out = (state_reg.sent >= limit_in);
endmodule
`default_nettype wire

// ---- verilog/p3s_scheduler.sv ----
// Port 3 transmit queue ratio scheduler with Avalon-MM registers
// Behaviour
// - Queue 2 control bit clear: strict priority over lower queues.
// - Queue 2 control set: limit to first-register bits 14:8, default 4.
// - Queue 3 control bit 7 clear: strict priority over lower queues.
// - Queue 3 control set: limit to first-register bits 6:0, default 8.
// - Queue 0 control bit 15 clear: sends only when no higher queue is eligible.
// - Queue 0 control set: limit to second-register bits 14:8, default 1.
// - Queue 1 control bit 7 clear: strict priority over queue 0.
// - Queue 1 control set: limit to second-register bits 6:0, default 2.
// - Indices d4 to db after the second register are reserved, nothing mapped.
`timescale 1ns/1ps
`default_nettype none
module p3s_scheduler
    import p3s_pkg::*;
#(
    parameter int PERIOD_CYCLES = P3S_PERIOD_CYCLES
) (
    input wire logic ref_clk_in, // Core clock, 100 MHz
    input wire logic resetn_in, // Sync reset, active low
    input wire logic [P3S_ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic [1:0] avs_response, // 00 ok, 10 slave error
    input wire logic [P3S_NQ-1:0] q_req_in, // Queue has a packet waiting
    input wire logic q_ready_in, // Queue manager can take a grant
    output logic [P3S_NQ-1:0] q_grant_out // One-hot grant, one cycle
);
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] high_weight;
        logic [15:0] low_weight;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic ack;
        logic [P3S_NQ-1:0] grant;
    } p3s_state_type;
    p3s_state_type state_reg;
    p3s_state_type state_next;

    logic period_tick;
    logic [P3S_NQ-1:0] ratio_mode;
    logic [P3S_NQ-1:0] spent;
    logic [P3S_NQ-1:0] eligible;
    logic [P3S_NQ-1:0] pick;
    logic [P3S_CNT_W-1:0] limit [P3S_NQ];
    logic [7:0] word_idx;
    logic req;
    logic hit_high;
    logic hit_low;
    logic hit_status;

    // -------------------------------------------------------------------
    // Period timer
    // -------------------------------------------------------------------
    p3s_period_timer #(
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .tick_out(period_tick)
    );

    // -------------------------------------------------------------------
    // Field extraction
    // -------------------------------------------------------------------
    assign ratio_mode[2] = state_reg.high_weight[P3S_UPPER_CTRL_BIT];
    assign limit[2] = state_reg.high_weight[P3S_UPPER_CNT_LSB +: P3S_CNT_W];
    assign ratio_mode[3] = state_reg.high_weight[P3S_LOWER_CTRL_BIT];
    assign limit[3] = state_reg.high_weight[P3S_LOWER_CNT_LSB +: P3S_CNT_W];
    assign ratio_mode[0] = state_reg.low_weight[P3S_UPPER_CTRL_BIT];
    assign limit[0] = state_reg.low_weight[P3S_UPPER_CNT_LSB +: P3S_CNT_W];
    assign ratio_mode[1] = state_reg.low_weight[P3S_LOWER_CTRL_BIT];
    assign limit[1] = state_reg.low_weight[P3S_LOWER_CNT_LSB +: P3S_CNT_W];

    // -------------------------------------------------------------------
    // Per-queue allowance
    // -------------------------------------------------------------------
    generate
        for (genvar q = 0; q < P3S_NQ; q++) begin : g_queue
            p3s_queue_credit #(
                .CNT_W(P3S_CNT_W)
            ) u_credit (
                .ref_clk_in(ref_clk_in),
                .resetn_in(resetn_in),
                .reload_in(period_tick),
                .limit_in(limit[q]),
                .used_in(state_reg.grant[q]),
                .spent_out(spent[q])
            );
            // Strict mode ignores the allowance; ratio mode waits once spent
            assign eligible[q] = q_req_in[q] && !(ratio_mode[q] && spent[q]);
        end
    endgenerate

    // -------------------------------------------------------------------
    // Priority pick
    // -------------------------------------------------------------------
    always_comb begin
        pick = '0;
        // Highest eligible queue first; a strict queue with work always wins
        // over every lower queue because it is never made ineligible.
        if (eligible[3]) begin
            pick[3] = 1'b1;
        end else if (eligible[2]) begin
            pick[2] = 1'b1;
        end else if (eligible[1]) begin
            pick[1] = 1'b1;
        end else if (eligible[0]) begin
            pick[0] = 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Register bus decode
    // -------------------------------------------------------------------
    assign word_idx = avs_address[P3S_ADDR_W-1:2];
    assign req = (avs_read || avs_write) && !state_reg.ack;
    assign hit_high = (word_idx == P3S_HIGH_WEIGHT_IDX);
    assign hit_low = (word_idx == P3S_LOW_WEIGHT_IDX);
    assign hit_status = (word_idx == P3S_STATUS_IDX);

    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.grant = '0;
        // A grant is a one-cycle pulse; the next pick waits a cycle so the
        // allowance counter has seen the previous grant.
        if (q_ready_in && state_reg.grant == '0) begin
            state_next.grant = pick;
        end
        if (req) begin
            state_next.ack = 1'b1;
            state_next.resp = 2'h0;
            state_next.rdata = 32'h0;
            if (hit_high) begin
                state_next.rdata = {16'h0, state_reg.high_weight};
            end else if (hit_low) begin
                state_next.rdata = {16'h0, state_reg.low_weight};
            end else if (hit_status && avs_read) begin
                state_next.rdata = {24'h0, spent, q_req_in};
            end else begin
                // Reserved window and every other word: no storage, error
                state_next.resp = 2'h2;
            end
        end
        // A write lands only at the edge where waitrequest is sampled low
        if (avs_write && state_reg.ack) begin
            if (hit_high) begin
                if (avs_byteenable[0]) begin
                    state_next.high_weight[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    state_next.high_weight[15:8] = avs_writedata[15:8];
                end
            end else if (hit_low) begin
                if (avs_byteenable[0]) begin
                    state_next.low_weight[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    state_next.low_weight[15:8] = avs_writedata[15:8];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            state_reg.high_weight <= P3S_HIGH_WEIGHT_RST;
            state_reg.low_weight <= P3S_LOW_WEIGHT_RST;
            state_reg.rdata <= 32'h0;
            state_reg.resp <= 2'h0;
            state_reg.ack <= 1'b0;
            state_reg.grant <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // One wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
    assign avs_readdata = state_reg.rdata;
    assign avs_response = state_reg.resp;
    assign q_grant_out = state_reg.grant;
endmodule
`default_nettype wire
